/* File: bench/mcio_asserts.sv */
// Port checker for the macrocell register and pin control block
`timescale 1ns/100ps
`include "mcio_regs.svh"
module mcio_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic global_clear_low_pin,
  input wire mcio_pkg::mcio_terms_s [`MCIO_NUM_MC-1:0] terms,
  input wire logic [`MCIO_NUM_MC-1:0] mc_out,
  input wire logic [`MCIO_NUM_MC-1:0] io_in,
  input wire logic [`MCIO_NUM_MC-1:0] io_out,
  input wire logic [`MCIO_NUM_MC-1:0] io_oe_n,
  input wire logic [`MCIO_NUM_MC-1:0] pin_in
);
  logic wr;
  logic plain;
  logic [2:0] age;
  logic [2:0] since;
  logic [7:0] mc0;
  logic [5:0] pins;
  // Only writes whose address and data are taken together are tracked
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign plain = age == 3'h7 && !mc0[2] && !mc0[7];
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      age <= 3'h7;
      since <= 3'h0;
      mc0 <= 8'h00;
      pins <= 6'h00;
    end
    else
    begin
      age <= wr ? 3'h0 : (age == 3'h7 ? age : age + 3'h1);
      since <= since == 3'h7 ? since : since + 3'h1;
      if (wr && s_axi_awaddr == `MCIO_ADDR_MC0)
        mc0 <= s_axi_wdata[7:0];
      if (wr && s_axi_awaddr == `MCIO_ADDR_PIN)
        pins <= s_axi_wdata[5:0];
    end
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_RST_LOW: assert property ($rose(rstn) |-> mc_out == 4'h0 && io_oe_n == 4'hF)
    else $error("outputs not cleared at reset");
  AST_PIN_SYNC: assert property (since == 3'h7 |-> pin_in == $past(io_in, 2))
    else $error("pin feedback wrong");
  AST_IO_OUT: assert property (io_out == mc_out)
    else $error("pin output differs from macrocell");
  AST_TRI: assert property (age == 3'h7 && pins[2:0] == 3'h0 |-> io_oe_n[0])
    else $error("tri-stated pin driven");
  AST_DRIVE: assert property (age == 3'h7 && pins[5:3] == 3'h1 |-> !io_oe_n[1])
    else $error("always-on pin not driven");
  AST_BYPASS: assert property (age == 3'h7 && mc0[2] && !mc0[7] |-> mc_out[0] == $past(terms[0].data_a))
    else $error("bypass output wrong");
  AST_CLEAR: assert property ((plain && terms[0].clear_term) [*3] |-> !mc_out[0])
    else $error("clear term ignored");
  AST_PRESET: assert property ((plain && global_clear_low_pin && terms[0].preset_term && !terms[0].clear_term) [*5] |-> mc_out[0])
    else $error("preset term ignored");
  AST_GCLR: assert property ((plain && mc0[6] && !global_clear_low_pin) [*5] |-> !mc_out[0])
    else $error("global clear ignored");
  cover property (wr);
  cover property (plain && terms[0].clear_term && terms[0].preset_term);
  cover property (age == 3'h7 && mc0[2]);
endmodule

/* File: bench/mcio_board.sv */
// Board logic sharing the device pins
`timescale 1ns/100ps
module mcio_board (
  input wire logic clock,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_n,
  input wire logic [3:0] board_en,
  input wire logic [3:0] board_val,
  output logic [3:0] io_in
);
  // Starts known so a floating pin never reads as unknown
  logic [3:0] last = 4'h0;
  always_ff @(posedge clock)
    last <= io_in;
  // A floating pin shows the inverse of its last level, so a stale value never passes
  always_comb
    for (int i = 0; i < 4; i++)
      io_in[i] = !io_oe_n[i] ? io_out[i] : board_en[i] ? board_val[i] : ~last[i];
endmodule

/* File: bench/mcio_top_tb.sv */
// Self-checking testbench of the macrocell register and pin control block
`timescale 1ns/100ps
`include "mcio_regs.svh"
module mcio_top_tb;
  logic clock = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, oe_pin_a = 1'b0, oe_pin_b = 1'b0;
  logic global_clock_pin_a = 1'b1, global_clock_pin_b = 1'b1, global_clear_low_pin = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, board_en = 4'h0, board_val = 4'h0;
  mcio_pkg::mcio_terms_s [3:0] terms = 24'h000000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] mc_out, io_in, io_out, io_oe_n, pin_in;
  int num_errors = 0, compares = 0;
  mcio_top dut_u (.clock, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .global_clock_pin_a, .global_clock_pin_b, .global_clear_low_pin, .oe_pin_a,
    .oe_pin_b, .terms, .mc_out, .io_in, .io_out, .io_oe_n, .pin_in);
  mcio_board board_u (.clock, .io_out, .io_oe_n, .board_en, .board_val, .io_in);
  initial
    forever #5 clock = ~clock;
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      tick(1);
      if (s_axi_awready && s_axi_awvalid)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      tick(1);
      if (s_axi_arready && s_axi_arvalid)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask
  task t_regs;
    chk(mc_out, 4'h0);
    chk(io_oe_n, 4'hF);
    axi_write(`MCIO_ADDR_MC0, 32'hFFFFFFFF, `MCIO_RESP_OKAY);
    axi_read(`MCIO_ADDR_MC0, 32'h000000FF, `MCIO_RESP_OKAY);
    axi_write(8'h48, 32'h1, `MCIO_RESP_SLVERR);
    axi_read(8'h48, 32'h0, `MCIO_RESP_SLVERR);
    axi_write(`MCIO_ADDR_STATUS, 32'h0, `MCIO_RESP_OKAY);
  endtask
  task pulse(input logic a, input logic b);
    terms[0].data_a <= a;
    terms[0].data_b <= b;
    tick(1);
    terms[0].clk_term <= 1'b1;
    tick(1);
    terms[0].clk_term <= 1'b0;
    tick(2);
  endtask
  // Each type is set from low, then taken back low by its own input pair
  task t_ff_types;
    for (int t = 0; t < 4; t++)
    begin
      axi_write(`MCIO_ADDR_MC0, 32'h10 | t, `MCIO_RESP_OKAY);
      terms[0].clear_term <= 1'b1;
      tick(1);
      terms[0].clear_term <= 1'b0;
      pulse(1'b1, 1'b0);
      chk(mc_out[0], 1'b1);
      pulse(1'(4'b0110 >> t), 1'(4'b1100 >> t));
      chk(mc_out[0], 1'b0);
    end
  endtask
  task gedge(input logic b);
    global_clock_pin_a <= b;
    global_clock_pin_b <= !b;
    tick(4);
    global_clock_pin_a <= 1'b1;
    global_clock_pin_b <= 1'b1;
    tick(4);
  endtask
  task t_global;
    axi_write(`MCIO_ADDR_GCLK, 32'h3, `MCIO_RESP_OKAY);
    axi_write(8'h04, 32'h08, `MCIO_RESP_OKAY);
    terms[1].data_a <= 1'b1;
    terms[2].data_a <= 1'b1;
    gedge(1'b1);
    chk(mc_out[2:1], 2'b10);
    terms[1].ena_term <= 1'b1;
    gedge(1'b0);
    chk(mc_out[1], 1'b0);
    gedge(1'b1);
    chk(mc_out[1], 1'b1);
  endtask
  task t_async;
    axi_write(`MCIO_ADDR_MC0, 32'h40, `MCIO_RESP_OKAY);
    terms[0].preset_term <= 1'b1;
    tick(8);
    chk(mc_out[0], 1'b1);
    terms[0].clear_term <= 1'b1;
    tick(3);
    chk(mc_out[0], 1'b0);
    terms[0].clear_term <= 1'b0;
    global_clear_low_pin <= 1'b0;
    tick(5);
    chk(mc_out[0], 1'b0);
    global_clear_low_pin <= 1'b1;
    terms[0].preset_term <= 1'b0;
    axi_write(`MCIO_ADDR_MC0, 32'h4, `MCIO_RESP_OKAY);
    terms[0].data_a <= 1'b1;
    tick(2);
    chk(mc_out[0], 1'b1);
    terms[0].data_a <= 1'b0;
    axi_write(8'h0C, 32'h98, `MCIO_RESP_OKAY);
    tick(2);
    chk(mc_out[3], 1'b1);
    chk(mc_out[0], 1'b0);
  endtask
  // Enable sources: pin a, pin b, pin 0, macrocell 0, pin 0 inverted
  task t_pins;
    logic [7:0] cfg [5];
    cfg = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h12};
    board_en <= 4'h1;
    board_val <= 4'h1;
    oe_pin_a <= 1'b1;
    axi_write(`MCIO_ADDR_PIN, 32'h688, `MCIO_RESP_OKAY);
    axi_write(`MCIO_ADDR_OE0, 32'h0, `MCIO_RESP_OKAY);
    for (int k = 0; k < 5; k++)
    begin
      axi_write(`MCIO_ADDR_OE0 + 8'h04, cfg[k], `MCIO_RESP_OKAY);
      tick(6);
      chk(io_oe_n, {!((5'b00101 >> k) & 5'h01), 3'b001});
    end
    chk(pin_in[1:0], 2'b11);
    axi_read(`MCIO_ADDR_PIN, 32'h688, `MCIO_RESP_OKAY);
  endtask
  task summarize;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    num_errors++;
    summarize();
  end
  initial
  begin
    tick(12);
    rstn <= 1'b1;
    tick(1);
    t_regs();
    t_ff_types();
    t_global();
    t_async();
    t_pins();
    summarize();
  end
endmodule
bind mcio_top mcio_asserts chk_u (.clock, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
  .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .global_clear_low_pin, .terms, .mc_out, .io_in,
  .io_out, .io_oe_n, .pin_in);

/* File: design/mcio_top.sv */
// Macrocell registers, global clock nets, output enables and pin buffers
// Contract
// [R1] Each register is set on its own to act as a D, T, JK or SR flipflop with its own clock source.
// [R2] A bypassed macrocell passes its logic straight through without the register.
// [R3] Each register picks a global clock, an enabled global clock or an array clock.
// [R4] With the enabled global clock a register captures only on edges where its enable term is high.
// [R5] With the array clock a register is clocked by its own product term.
// [R6] Two global clock nets each take the true or inverted form of either global clock pin.
// [R7] Preset and clear terms act asynchronously and are active high; here they are registered and take effect at the next clock edge.
// [R8] The active-low global clear pin may drive the clear of each register on its own choice.
// [R9] All registers come up cleared, so registered outputs start low unless set to come up high.
// [R10] A high power-up output stores the inverted value and inverts it after the register.
// [R11] Each pin is on its own an input, an output or a bidirectional pin.
// [R12] Each pin buffer is enabled from a global output enable, constant low or constant high.
// [R13] There are six global output enables, each from an enable pin, an I/O pin or a macrocell.
// [R14] A buffer tied low keeps the pin in high impedance so it works only as an input.
// [R15] A buffer tied high keeps the pin driver always on.
// [R16] Pin feedback and macrocell feedback stay apart, so a macrocell can serve buried logic.
// [R17] Clear wins over preset, and the global clear is ORed with the clear term; with pwrhi set, preset wins and the global clear is ORed with preset.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "mcio_regs.svh"
module mcio_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic global_clock_pin_a,
  input wire logic global_clock_pin_b,
  input wire logic global_clear_low_pin,
  input wire logic oe_pin_a,
  input wire logic oe_pin_b,
  input wire mcio_pkg::mcio_terms_s [`MCIO_NUM_MC-1:0] terms,
  output logic [`MCIO_NUM_MC-1:0] mc_out,
  input wire logic [`MCIO_NUM_MC-1:0] io_in,
  output logic [`MCIO_NUM_MC-1:0] io_out,
  output logic [`MCIO_NUM_MC-1:0] io_oe_n,
  output logic [`MCIO_NUM_MC-1:0] pin_in
);

  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    logic [7:0] off;
    off = 8'h00;
    reg_sel = `MCIO_SEL_NONE;
    if (a[1:0] != 2'h0)
    begin
      reg_sel = `MCIO_SEL_NONE;
    end
    else if (a >= `MCIO_ADDR_MC0 && a <= `MCIO_ADDR_MC3)
    begin
      off = a - `MCIO_ADDR_MC0;
      reg_sel = off[5:2];
    end
    else if (a >= `MCIO_ADDR_OE0 && a <= `MCIO_ADDR_OE5)
    begin
      off = a - `MCIO_ADDR_OE0;
      reg_sel = off[5:2] + `MCIO_SEL_OE0;
    end
    else if (a == `MCIO_ADDR_GCLK)
      reg_sel = `MCIO_SEL_GCLK;
    else if (a == `MCIO_ADDR_PIN)
      reg_sel = `MCIO_SEL_PIN;
    else if (a == `MCIO_ADDR_STATUS)
      reg_sel = `MCIO_SEL_STATUS;
  endfunction

  function automatic logic [15:0] cfg_mask(input logic [3:0] s);
    if (s < `MCIO_SEL_GCLK)
      cfg_mask = `MCIO_MASK_MC;
    else if (s == `MCIO_SEL_GCLK)
      cfg_mask = `MCIO_MASK_GCLK;
    else if (s < `MCIO_SEL_PIN)
      cfg_mask = `MCIO_MASK_OE;
    else
      cfg_mask = `MCIO_MASK_PIN;
  endfunction

  function automatic logic ff_next(input mcio_pkg::mcio_ff_e t, input logic q,
                                   input logic a, input logic b);
    case (t)
      mcio_pkg::MCIO_FF_D: ff_next = a;
      mcio_pkg::MCIO_FF_T: ff_next = q ^ a;
      mcio_pkg::MCIO_FF_JK: ff_next = (a & b) ? ~q : (a | (q & ~b));
      mcio_pkg::MCIO_FF_SR: ff_next = (a & b) ? q : (a | (q & ~b));
      default: ff_next = q;
    endcase
  endfunction

  logic [`MCIO_SYNC_W-1:0] sync1;
  logic [`MCIO_SYNC_W-1:0] sync2;
  logic [15:0] cfg [0:`MCIO_NUM_CFG-1];
  logic [`MCIO_NUM_MC-1:0] q;
  logic [`MCIO_NUM_MC-1:0] clk_term_prev;
  logic [1:0] gnet_prev;
  logic armed;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Pins cross in through two flops; only the second stage is read
  wire [`MCIO_SYNC_W-1:0] raw_pins = {io_in, oe_pin_b, oe_pin_a, global_clear_low_pin,
                                      global_clock_pin_b, global_clock_pin_a};
  wire clk_a_s = sync2[0];
  wire clk_b_s = sync2[1];
  wire gclr_s = ~sync2[2];
  wire oe_a_s = sync2[3];
  wire oe_b_s = sync2[4];
  wire [`MCIO_NUM_MC-1:0] pin_s = sync2[`MCIO_SYNC_W-1:5];

  wire [1:0] gnet_val;
  wire [1:0] gnet_rise;
  wire [`MCIO_NUM_GOE-1:0] goe;
  wire [`MCIO_NUM_MC-1:0] next_q;
  wire [`MCIO_NUM_MC-1:0] next_out;
  wire [`MCIO_NUM_MC-1:0] next_oe_n;

  // [R6] Global clock nets
  genvar n;
  generate
    for (n = 0; n < 2; n++)
    begin : g_net
      wire mcio_pkg::mcio_gnet_cfg_s gc = cfg[`MCIO_SEL_GCLK][2*n+1:2*n];
      assign gnet_val[n] = (gc.src_b ? clk_b_s : clk_a_s) ^ gc.invert;
      // Armed blocks a false edge from an inverted net right after reset
      assign gnet_rise[n] = gnet_val[n] & ~gnet_prev[n] & armed;
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < `MCIO_NUM_MC; i++)
    begin : g_mc
      wire mcio_pkg::mcio_mc_cfg_s mc = cfg[i][7:0];
      wire mcio_pkg::mcio_terms_s t = terms[i];
      wire inv = mc.pwrhi;
      // [R10] Inverted storage swaps set and reset inputs
      wire swap = inv & (mc.ff_type == mcio_pkg::MCIO_FF_JK || mc.ff_type == mcio_pkg::MCIO_FF_SR);
      wire fa = swap ? t.data_b : (t.data_a ^ (inv & (mc.ff_type == mcio_pkg::MCIO_FF_D)));
      wire fb = swap ? t.data_a : t.data_b;
      wire gedge = gnet_rise[mc.gnet];
      // [R5] Array clock edge
      wire aedge = t.clk_term & ~clk_term_prev[i];
      // [R3] Clock source select
      wire cap_global = (mc.clk_mode == mcio_pkg::MCIO_CK_GLOBAL) & gedge;
      // [R4] Enable term qualifies global edge
      wire cap_en = (mc.clk_mode == mcio_pkg::MCIO_CK_GLOBAL_EN) & gedge & t.ena_term;
      wire cap_arr = (mc.clk_mode == mcio_pkg::MCIO_CK_ARRAY) & aedge;
      wire cap = cap_global | cap_en | cap_arr;
      // [R8] Optional global clear, ORed in
      wire clr = (mc.gclr_en & gclr_s) | (inv ? t.preset_term : t.clear_term);
      // [R7] Active-high preset term
      wire pre = inv ? t.clear_term : t.preset_term;
      // [R17] Clear beats preset
      wire hold_or_cap = cap ? ff_next(mc.ff_type, q[i], fa, fb) : q[i];
      // [R1] Flipflop type per register
      assign next_q[i] = clr ? 1'b0 : (pre ? 1'b1 : hold_or_cap);
      // [R2] Bypass path
      assign next_out[i] = mc.bypass ? t.data_a : (q[i] ^ inv);
      wire [2:0] psel = cfg[`MCIO_SEL_PIN][3*i+2:3*i];
      wire [2:0] gidx = psel - `MCIO_PIN_GOE0;
      // [R12] Buffer control select
      wire en = (psel == `MCIO_PIN_TRI) ? 1'b0 : ((psel == `MCIO_PIN_DRIVE) ? 1'b1 : goe[gidx]);
      // [R14] Tied low tri-states the pin
      // [R15] Tied high always drives
      assign next_oe_n[i] = ~en;
    end
  endgenerate

  // [R13] Global output enable sources
  genvar k;
  generate
    for (k = 0; k < `MCIO_NUM_GOE; k++)
    begin : g_goe
      wire mcio_pkg::mcio_oe_cfg_s oc = cfg[`MCIO_SEL_OE0 + k][4:0];
      wire src_pin = (oc.src == mcio_pkg::MCIO_OE_PIN_A) ? oe_a_s : oe_b_s;
      wire src_io = (oc.src == mcio_pkg::MCIO_OE_IO_PIN) ? pin_s[oc.idx] : mc_out[oc.idx];
      assign goe[k] = (oc.src[1] ? src_io : src_pin) ^ oc.invert;
    end
  endgenerate

  wire [3:0] wsel = reg_sel(aw_addr);
  wire [3:0] rsel = reg_sel(s_axi_araddr);
  wire do_write = aw_got & w_got & ~s_axi_bvalid;
  wire wr_cfg = do_write && (wsel < `MCIO_SEL_STATUS);
  wire [15:0] strb_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [15:0] wr_word = ((w_data[15:0] & strb_mask) | (cfg[wsel] & ~strb_mask)) & cfg_mask(wsel);
  wire [13:0] status = {goe, pin_s, q};
  wire [31:0] rword = (rsel < `MCIO_SEL_STATUS) ? {16'h0000, cfg[rsel]} :
                      ((rsel == `MCIO_SEL_STATUS) ? {18'h00000, status} : 32'h00000000);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1 <= `MCIO_SYNC_RST;
      sync2 <= `MCIO_SYNC_RST;
    end
    else
    begin
      sync1 <= raw_pins;
      sync2 <= sync1;
    end
  end

  // [R9] Power-up clears every register
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
      clk_term_prev <= '0;
      gnet_prev <= 2'h0;
      armed <= 1'b0;
      mc_out <= '0;
      io_out <= '0;
      io_oe_n <= '1;
    end
    else
    begin
      q <= next_q;
      for (int m = 0; m < `MCIO_NUM_MC; m++)
        clk_term_prev[m] <= terms[m].clk_term;
      gnet_prev <= gnet_val;
      armed <= 1'b1;
      mc_out <= next_out;
      // [R11] Pin direction from its buffer control
      io_out <= next_out;
      io_oe_n <= next_oe_n;
    end
  end

  // [R16] Pin feedback independent of the macrocell
  assign pin_in = pin_s;

  // Write channel: address and data may come in either order
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int c = 0; c < `MCIO_NUM_CFG; c++)
        cfg[c] <= `MCIO_CFG_RST;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MCIO_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_cfg)
        cfg[wsel] <= wr_word;
      if (do_write)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == `MCIO_SEL_NONE) ? `MCIO_RESP_SLVERR : `MCIO_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read data is captured at the address handshake, so status is that cycle's
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `MCIO_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rword;
      s_axi_rresp <= (rsel == `MCIO_SEL_NONE) ? `MCIO_RESP_SLVERR : `MCIO_RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* File: inc/mcio_pkg.sv */
// Types of the macrocell register and I/O control block
package mcio_pkg;
  typedef enum logic [1:0] {
    MCIO_FF_D = 2'b00,
    MCIO_FF_T = 2'b01,
    MCIO_FF_JK = 2'b10,
    MCIO_FF_SR = 2'b11
  } mcio_ff_e;
  typedef enum logic [1:0] {
    MCIO_CK_GLOBAL = 2'b00,
    MCIO_CK_GLOBAL_EN = 2'b01,
    MCIO_CK_ARRAY = 2'b10,
    MCIO_CK_OFF = 2'b11
  } mcio_clk_e;
  typedef enum logic [1:0] {
    MCIO_OE_PIN_A = 2'b00,
    MCIO_OE_PIN_B = 2'b01,
    MCIO_OE_IO_PIN = 2'b10,
    MCIO_OE_MACROCELL = 2'b11
  } mcio_oesrc_e;
  typedef struct packed {
    logic pwrhi;
    logic gclr_en;
    logic gnet;
    mcio_clk_e clk_mode;
    logic bypass;
    mcio_ff_e ff_type;
  } mcio_mc_cfg_s;
  typedef struct packed {
    logic invert;
    logic src_b;
  } mcio_gnet_cfg_s;
  typedef struct packed {
    logic invert;
    logic [1:0] idx;
    mcio_oesrc_e src;
  } mcio_oe_cfg_s;
  typedef struct packed {
    logic data_a;
    logic data_b;
    logic clk_term;
    logic ena_term;
    logic preset_term;
    logic clear_term;
  } mcio_terms_s;
endpackage

/* File: inc/mcio_regs.svh */
// Register map, field masks, reset values and sizes of the macrocell I/O block
`ifndef MCIO_REGS_SVH
`define MCIO_REGS_SVH
`define MCIO_NUM_MC 4
`define MCIO_NUM_GOE 6
`define MCIO_SYNC_W 9
`define MCIO_SYNC_RST 9'h004
`define MCIO_ADDR_MC0 8'h00
`define MCIO_ADDR_MC3 8'h0C
`define MCIO_ADDR_GCLK 8'h10
`define MCIO_ADDR_OE0 8'h20
`define MCIO_ADDR_OE5 8'h34
`define MCIO_ADDR_PIN 8'h40
`define MCIO_ADDR_STATUS 8'h44
`define MCIO_SEL_GCLK 4'h4
`define MCIO_SEL_OE0 4'h5
`define MCIO_SEL_PIN 4'hB
`define MCIO_SEL_STATUS 4'hC
`define MCIO_SEL_NONE 4'hF
`define MCIO_NUM_CFG 12
`define MCIO_MASK_MC 16'h00FF
`define MCIO_MASK_GCLK 16'h000F
`define MCIO_MASK_OE 16'h001F
`define MCIO_MASK_PIN 16'h0FFF
`define MCIO_CFG_RST 16'h0000
`define MCIO_PIN_TRI 3'h0
`define MCIO_PIN_DRIVE 3'h1
`define MCIO_PIN_GOE0 3'h2
`define MCIO_RESP_OKAY 2'h0
`define MCIO_RESP_SLVERR 2'h2
`endif
